// ==== hw/first_order_filter.sv ====
`timescale 1ns/1ps
module first_order_filter #(
    parameter int SHIFT = 12
) (
    // Clock and reset
    input  wire logic                                  core_clk,
    input  wire logic                                  arst_n,
    // Control
    input  wire logic                                  clear,
    input  wire logic                                  step,
    // Data
    input  wire logic signed [meter_pkg::FILT_W-1:0]   sample_in,
    output logic signed [meter_pkg::FILT_W-1:0]        low_out,
    output logic signed [meter_pkg::FILT_W-1:0]        high_out
);
    import meter_pkg::*;

    typedef struct packed {
        logic signed [FACC_W-1:0] acc;
        logic signed [FILT_W-1:0] high;
    } filt_state_t;

    filt_state_t q;
    filt_state_t d;
    logic signed [FILT_W-1:0] low;

    // =====================================================================
    // Single-pole section, low = acc / 2^SHIFT
    assign low = FILT_W'(q.acc >>> SHIFT);

    always_comb begin
        d = q;
        if (step) begin
            d.acc  = q.acc + FACC_W'(sample_in) - FACC_W'(low); // [R4] [R9]
            d.high = sample_in - low;                            // [R2]
        end
        if (clear) begin
            d = '0;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign low_out  = low;
    assign high_out = q.high;

    // =====================================================================
    // Checks
    chk_dc_settled: assert property (@(posedge core_clk) disable iff (!arst_n) // [R2] [R4]
        step && !clear && sample_in == low |=> q.acc == $past(q.acc))
        else $error("filter state moved at a settled input");
endmodule // first_order_filter

// ==== hw/meter_pkg.sv ====
package meter_pkg;
    // =====================================================================
    // Clock and sample timing
    localparam int CLK_HZ     = 100_000_000;
    localparam int SAMPLE_HZ  = 833_000;
    localparam int SAMPLE_DIV = CLK_HZ / SAMPLE_HZ;
    localparam int DIV_W      = 7;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SAMPLE_DIV - 1);
    localparam logic [DIV_W-1:0] DIV_RESET = 7'h00;

    // =====================================================================
    // Datapath widths
    localparam int SMP_W  = 16;
    localparam int HP_W   = 18;
    localparam int FILT_W = 34;
    localparam int FACC_W = FILT_W + 16;
    localparam int SUM_W  = 36;
    localparam int ACC_W  = 44;
    localparam int STG_N  = 5;

    // =====================================================================
    // Filter coefficients as shift counts
    localparam int HPF_SHIFT = 12;
    localparam int LPF_SHIFT = 14;

    // =====================================================================
    // Synchronised pin positions
    localparam int PIN_SUP  = 0;
    localparam int PIN_MODE = 1;
    localparam int PIN_S0   = 2;
    localparam int PIN_S1   = 3;

    // =====================================================================
    // Frequency conversion
    localparam logic signed [ACC_W-1:0] CAL_THR = 44'h400_0000_0000;
    localparam logic [7:0] RATIO_0 = 8'hA0;
    localparam logic [7:0] RATIO_1 = 8'h50;
    localparam logic [7:0] RATIO_2 = 8'h28;
    localparam logic [7:0] RATIO_3 = 8'h14;
endpackage

// ==== hw/polyphase_active_power_datapath.sv ====
`timescale 1ns/1ps
// Contract
// R1 - Take six 16-bit converter streams, one current and voltage per phase, 833 kHz.
// R2 - High-pass each current channel to strip dc before multiplying.
// R3 - Multiply each phase's filtered current by its voltage sample.
// R4 - Low-pass each phase product separately to extract its active power.
// R5 - Add the three filtered phase powers into total active power.
// R6 - Slow pulses come from long accumulation of total power.
// R7 - Calibration pulse uses a short accumulation, following instantaneous power.
// R8 - Power path passes content to 14 kHz at a 10 MHz master clock; the code's master clock CLK_HZ is 100 MHz, divided by 120.
// R9 - Multiply and filter arithmetic is signed and linear.
// R10 - Sum-mode high gives arithmetic sum, low gives sum of magnitudes.
// R11 - Two rate-select bits pick one of four slow output scalings.
// R12 - Calibration rate reaches up to 160 times the slow rate.
// R13 - Invalid supply holds the datapath in reset with no pulses.
// R14 - Everything runs on the master clock at a fixed derived sample rate.
module polyphase_active_power_datapath (
    // Clock and reset
    input  wire logic                                  core_clk,
    input  wire logic                                  arst_n,
    // Supply monitor and mode pins
    input  wire logic                                  supply_ok,
    input  wire logic                                  sum_mode_select,
    input  wire logic                                  rate_select_bit0,
    input  wire logic                                  rate_select_bit1,
    // Converter sample streams
    input  wire logic signed [meter_pkg::SMP_W-1:0]    current_a,
    input  wire logic signed [meter_pkg::SMP_W-1:0]    current_b,
    input  wire logic signed [meter_pkg::SMP_W-1:0]    current_c,
    input  wire logic signed [meter_pkg::SMP_W-1:0]    voltage_a,
    input  wire logic signed [meter_pkg::SMP_W-1:0]    voltage_b,
    input  wire logic signed [meter_pkg::SMP_W-1:0]    voltage_c,
    // Pulse outputs
    output logic                                       calibration_pulse_out,
    output logic                                       slow_pulse_out_one,
    output logic                                       slow_pulse_out_two
);
    import meter_pkg::*;

    typedef struct packed {
        logic [3:0]                  meta;
        logic [3:0]                  pins;
        logic [DIV_W-1:0]            div;
        logic [STG_N-1:0]            stg;
        logic [2:0][SMP_W-1:0]       cur;
        logic [2:0][SMP_W-1:0]       vol;
        logic [2:0][FILT_W-1:0]      prod;
        logic signed [SUM_W-1:0]     total;
        logic signed [ACC_W-1:0]     acc;
        logic [7:0]                  ratio_cnt;
        logic                        next_two;
        logic                        cal;
        logic                        one;
        logic                        two;
    } dp_state_t;

    // =====================================================================
    // Decoders
    function automatic logic [7:0] ratio_of(input logic [1:0] sel);
        case (sel)
            2'h0:    ratio_of = RATIO_0;
            2'h1:    ratio_of = RATIO_1;
            2'h2:    ratio_of = RATIO_2;
            default: ratio_of = RATIO_3;
        endcase
    endfunction

    function automatic logic signed [SUM_W-1:0] mag(input logic signed [FILT_W-1:0] v);
        logic signed [SUM_W-1:0] w;
        w = SUM_W'(v);
        mag = (w < 0) ? -w : w;
    endfunction

    dp_state_t                      q;
    dp_state_t                      d;
    logic [2:0][SMP_W-1:0]          cur_in;
    logic [2:0][SMP_W-1:0]          vol_in;
    logic signed [FILT_W-1:0]       hp [3];
    logic signed [FILT_W-1:0]       lp [3];
    logic                           hold;
    logic                           tick;
    logic                           hit;
    logic signed [SUM_W-1:0]        sum_c;
    logic signed [ACC_W-1:0]        acc_add;

    assign cur_in = {current_c, current_b, current_a};
    assign vol_in = {voltage_c, voltage_b, voltage_a};
    assign hold   = !q.pins[PIN_SUP];
    assign tick   = (q.div == DIV_LAST);

    // =====================================================================
    // Per-phase filters
    for (genvar i = 0; i < 3; i++) begin : g_phase
        first_order_filter #(
            .SHIFT(HPF_SHIFT)
        ) u_dc_removal_filter (
            .core_clk  (core_clk),
            .arst_n    (arst_n),
            .clear     (hold),
            .step      (q.stg[0]),
            .sample_in (FILT_W'($signed(q.cur[i]))),
            .low_out   (),
            .high_out  (hp[i])
        ); // [R2]
        first_order_filter #(
            .SHIFT(LPF_SHIFT)
        ) u_power_smoothing_filter (
            .core_clk  (core_clk),
            .arst_n    (arst_n),
            .clear     (hold),
            .step      (q.stg[2]),
            .sample_in ($signed(q.prod[i])),
            .low_out   (lp[i]),
            .high_out  ()
        ); // [R4]
    end

    // =====================================================================
    // Next state
    always_comb begin
        d       = q;
        hit     = 1'b0;
        sum_c   = '0;
        acc_add = q.acc;
        d.meta  = {rate_select_bit1, rate_select_bit0, sum_mode_select, supply_ok};
        d.pins  = q.meta;
        d.div   = tick ? DIV_RESET : DIV_W'(q.div + 1'b1);            // [R14]
        d.stg   = {q.stg[STG_N-2:0], tick};                          // [R14] [R8]
        if (tick) begin
            d.cur = cur_in;                                          // [R1]
            d.vol = vol_in;
            d.cal = 1'b0;
            d.one = 1'b0;
            d.two = 1'b0;
        end
        if (q.stg[1]) begin
            for (int i = 0; i < 3; i++) begin
                d.prod[i] = FILT_W'($signed(hp[i][HP_W-1:0]) * $signed(q.vol[i])); // [R3] [R9]
            end
        end
        for (int i = 0; i < 3; i++) begin
            sum_c = sum_c + (q.pins[PIN_MODE] ? SUM_W'(lp[i]) : mag(lp[i])); // [R5] [R10]
        end
        if (q.stg[3]) begin
            d.total = sum_c;
        end
        if (q.stg[4]) begin
            // Negative totals add nothing; reverse energy gives no pulses except in sum-of-magnitudes mode (sum-mode low)
            acc_add = q.acc + ((q.total > 0) ? ACC_W'(q.total) : ACC_W'(0)); // [R7]
            if (acc_add >= CAL_THR) begin
                hit     = 1'b1;
                acc_add = acc_add - CAL_THR;
            end
            d.acc = acc_add;
        end
        if (hit) begin
            d.cal = 1'b1;                                            // [R7]
            if (q.ratio_cnt >= ratio_of(q.pins[PIN_S1:PIN_S0]) - 8'h01) begin // [R6] [R11] [R12]
                d.ratio_cnt = 8'h00;
                d.next_two  = ~q.next_two;
                if (q.next_two) begin
                    d.two = 1'b1;
                end else begin
                    d.one = 1'b1;
                end
            end else begin
                d.ratio_cnt = q.ratio_cnt + 8'h01;
            end
        end
        if (hold) begin
            d = '{meta: d.meta, pins: d.pins, default: '0};          // [R13]
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign calibration_pulse_out = q.cal;
    assign slow_pulse_out_one    = q.one;
    assign slow_pulse_out_two    = q.two;

    // =====================================================================
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    chk_supply_hold: assert property (hold |=> !q.cal && !q.one && !q.two && q.acc == 0) // [R13]
        else $error("pulses or energy while supply invalid");
    chk_tick_wrap: assert property (tick && !hold |=> q.div == DIV_RESET && q.stg[0]) // [R14]
        else $error("sample divider did not wrap");
    chk_sample_take: assert property ( // [R1]
        tick && !hold |=> q.cur == $past(cur_in) && q.vol == $past(vol_in))
        else $error("samples not captured on tick");
    chk_pipe_order: assert property ( // [R14] [R8]
        q.stg[0] && !hold ##1 !hold [*3]
        |-> ($past(q.stg[1], 2) && $past(q.stg[2]) && q.stg[3]) ##1 q.stg[4])
        else $error("pipeline stages out of order");
    chk_phase_product: assert property ( // [R3] [R9]
        q.stg[1] && !hold |=> q.prod[0] ==
            FILT_W'($signed($past(hp[0][HP_W-1:0])) * $signed($past(q.vol[0]))))
        else $error("phase product wrong");
    chk_arith_total: assert property ( // [R5] [R10]
        q.stg[3] && !hold && q.pins[PIN_MODE] |=> q.total ==
            SUM_W'($past(lp[0])) + SUM_W'($past(lp[1])) + SUM_W'($past(lp[2])))
        else $error("arithmetic total wrong");
    chk_abs_total: assert property (q.stg[3] && !hold && !q.pins[PIN_MODE] |=> q.total >= 0) // [R10]
        else $error("magnitude total negative");
    chk_cal_pulse: assert property ( // [R7]
        q.stg[4] && !hold && hit ##1 !hold |-> q.cal ##1 q.cal)
        else $error("calibration pulse missing");
    chk_slow_ratio: assert property ( // [R6] [R11] [R12]
        $rose(q.one) || $rose(q.two) |-> $past(hit) &&
            $past(q.ratio_cnt) >= $past(ratio_of(q.pins[PIN_S1:PIN_S0])) - 8'h01)
        else $error("slow pulse not at ratio boundary");
    chk_slow_alternate: assert property (!(q.one && q.two)) // [R6]
        else $error("both slow outputs high");

    cov_cal_hit: cover property (hit && !hold);
    cov_slow_two: cover property ($rose(q.two));
    cov_abs_hit: cover property (hit && !q.pins[PIN_MODE] && q.pins[PIN_S1:PIN_S0] == 2'h3);
endmodule // polyphase_active_power_datapath

// ==== testbench/converter_model.sv ====
`timescale 1ns/1ps
// =====================================================================
// Square-wave converter streams, one current and one voltage shape
module converter_model (
    // Clock and reset
    input  wire logic                                core_clk,
    input  wire logic                                arst_n,
    // Waveform shape
    input  wire logic signed [meter_pkg::SMP_W-1:0]  cur_amp,
    input  wire logic signed [meter_pkg::SMP_W-1:0]  cur_dc,
    input  wire logic signed [meter_pkg::SMP_W-1:0]  vol_amp,
    // Sample streams
    output logic signed [meter_pkg::SMP_W-1:0]       cur_smp,
    output logic signed [meter_pkg::SMP_W-1:0]       vol_smp
);
    import meter_pkg::*;
    logic [8:0] cnt_q;
    logic       sign_q;
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= 9'h000;
            sign_q <= 1'b0;
        end else begin
            cnt_q <= (cnt_q == 9'h1DF) ? 9'h000 : cnt_q + 9'h001;
            if (cnt_q == 9'h1DF) sign_q <= ~sign_q;
        end
    end
    // New 16-bit samples every clock, launched after the edge
    always @(posedge core_clk) begin
        #1;
        cur_smp <= sign_q ? cur_dc - cur_amp : cur_dc + cur_amp;
        vol_smp <= sign_q ? -vol_amp : vol_amp;
    end
endmodule // converter_model

// ==== testbench/polyphase_active_power_datapath_tb_top.sv ====
`timescale 1ns/1ps
module polyphase_active_power_datapath_tb_top;
    import meter_pkg::*;
    logic                    core_clk = 1'b0;
    logic                    arst_n = 1'b0;
    logic                    supply_ok = 1'b0;
    logic                    sum_mode_select = 1'b1;
    logic                    rate_select_bit0 = 1'b0;
    logic                    rate_select_bit1 = 1'b0;
    logic signed [SMP_W-1:0] cur_amp = 16'h0000;
    logic signed [SMP_W-1:0] cur_dc = 16'h0000;
    logic signed [SMP_W-1:0] vol_amp = 16'h0000;
    logic signed [SMP_W-1:0] cur_smp;
    logic signed [SMP_W-1:0] vol_smp;
    logic                    cal;
    logic                    slow_one;
    logic                    slow_two;
    int                      bad_count = 0;
    int                      tests_run = 0;
    int                      pulse_n = 0;
    int                      cyc = 0;

    always #5 core_clk = ~core_clk;

    converter_model conv (.core_clk(core_clk), .arst_n(arst_n), .cur_amp(cur_amp),
        .cur_dc(cur_dc), .vol_amp(vol_amp), .cur_smp(cur_smp), .vol_smp(vol_smp));

    polyphase_active_power_datapath dut (.core_clk(core_clk), .arst_n(arst_n),
        .supply_ok(supply_ok), .sum_mode_select(sum_mode_select),
        .rate_select_bit0(rate_select_bit0), .rate_select_bit1(rate_select_bit1),
        .current_a(cur_smp), .current_b(cur_smp), .current_c(cur_smp),
        .voltage_a(vol_smp), .voltage_b(vol_smp), .voltage_c(vol_smp),
        .calibration_pulse_out(cal), .slow_pulse_out_one(slow_one),
        .slow_pulse_out_two(slow_two));

    // Cycles where any output is not a clean low, plus hang limit
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cal !== 1'b0 || slow_one !== 1'b0 || slow_two !== 1'b0) pulse_n <= pulse_n + 1;
        if (cyc == 80000) begin
            bad_count = bad_count + 1;
            report_and_stop();
        end
    end

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
        tests_run = tests_run + 1;
        if (seen !== exp) begin
            $display("CHECK FAILED %s expected %0d seen %0d", name, exp, seen);
            bad_count = bad_count + 1;
        end
    endtask

    task automatic run_quiet(input string name, input int n);
        pulse_n = 0;
        repeat (n) @(posedge core_clk);
        #1;
        check(name, 0, pulse_n);
        $display("test %s done", name);
    endtask

    // Strong in-phase power, but the monitor holds the path cleared
    task automatic test_supply_low();
        supply_ok = 1'b0;
        cur_amp = 16'h7000;
        vol_amp = 16'h7000;
        run_quiet("supply_low", 3000);
        check("total_held", 32'h0, {31'h0, $signed(dut.q.total) != 0});
    endtask

    // Pure dc on current must not build energy
    task automatic test_dc_offset();
        supply_ok = 1'b1;
        cur_amp = 16'h0000;
        cur_dc = 16'h4000;
        vol_amp = 16'h4000;
        run_quiet("dc_offset", 20000);
        check("dc_decaying", 32'h1, {31'h0, dut.hp[0] < 34'sh4000});
        cur_dc = 16'h0000;
    endtask

    // Antiphase current and voltage give negative total power
    task automatic test_reverse();
        sum_mode_select = 1'b1;
        cur_amp = 16'h7000;
        vol_amp = 16'h9000;
        run_quiet("reverse_power", 20000);
        check("reverse_total", 32'h1, {31'h0, $signed(dut.q.total) < 0});
    endtask

    // Every rate setting in both sum modes, reverse power kept on
    task automatic test_modes();
        for (int m = 0; m < 8; m++) begin
            sum_mode_select = m[2];
            rate_select_bit1 = m[1];
            rate_select_bit0 = m[0];
            run_quiet("mode_rate_idle", 1500);
            check("total_sign", m[2] ? 32'h0 : 32'h1, {31'h0, $signed(dut.q.total) > 0});
        end
    endtask

    // Reset mid-run drops every output at once
    task automatic test_mid_reset();
        cur_amp = 16'h7000;
        vol_amp = 16'h7000;
        repeat (700) @(posedge core_clk);
        #1;
        arst_n = 1'b0;
        #2;
        check("outputs_in_reset", 32'h0, {29'h0, cal, slow_one, slow_two});
        check("total_in_reset", 32'h0, {31'h0, $signed(dut.q.total) != 0});
        repeat (3) @(posedge core_clk);
        #1;
        arst_n = 1'b1;
        supply_ok = 1'b0;
        run_quiet("after_reset_supply_low", 500);
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge core_clk);
        #1;
        arst_n = 1'b1;
        test_supply_low();
        test_dc_offset();
        test_reverse();
        test_modes();
        test_mid_reset();
        report_and_stop();
    end
endmodule // polyphase_active_power_datapath_tb_top
